// [verilog/lcrf_lane_regs.sv]
// Operation
// R1 - lane 5 bit 1: rw power-off, reset 0, drives power-off vector bit 5
// R2 - lane 4 bit 1: rw power-off, reset 0, drives power-off vector bit 4
// R3 - transport layer reads power-off vector as dropped lanes on reconfiguration
// R4 - outside logic masks lane receive transceiver resets with power-off bits
// R5 - lane 4 bit 0: rw invert, reset 0, inverts lane 4 transmit data
// R6 - lane 5 bit 0: rw invert, reset 0, inverts lane 5 transmit data
// R7 - bits 9:2 of each register: rw spare field, reset 0, no effect
// R8 - power-off bit is stored even where a variant ignores it
// R9 - bits 31:10 read zero, writes there ignored
`timescale 1ns/1ps
`default_nettype none
module lcrf_lane_regs
    import lcrf_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [lcrf_pkg::LCRF_ADDR_W-1:0] paddr,
    input wire logic [lcrf_pkg::LCRF_DATA_W-1:0] pwdata,
    output logic [lcrf_pkg::LCRF_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [lcrf_pkg::LCRF_LANES-1:0] lane_power_off,
    output logic lane_four_invert,
    output logic lane_five_invert,
    output logic [lcrf_pkg::LCRF_SPARE_W-1:0] lane_four_spare,
    output logic [lcrf_pkg::LCRF_SPARE_W-1:0] lane_five_spare
);
    import lcrf_pkg::*;

    // one entry per lane: 0 is lane 4, 1 is lane 5
    logic [1:0] invert_reg;
    logic [1:0] power_off_reg;
    logic [LCRF_SPARE_W-1:0] spare_reg [2];
    logic [LCRF_DATA_W-1:0] prdata_reg;
    logic pslverr_reg;
    logic loaded_reg;
    logic capture;
    logic access;
    logic [1:0] hit;

    function automatic logic [1:0] lane_hit(input logic [LCRF_ADDR_W-1:0] a);
        lane_hit = {a == LCRF_LANE_FIVE_CONTROL_OFF, a == LCRF_LANE_FOUR_CONTROL_OFF};
    endfunction

    // reserved bits stay zero in every word that leaves the block
    function automatic logic [LCRF_DATA_W-1:0] lane_word(
        input logic inv,
        input logic pwr,
        input logic [LCRF_SPARE_W-1:0] spr
    );
        lane_word = '0; // see R9
        lane_word[LCRF_INVERT_BIT] = inv;
        lane_word[LCRF_POWER_OFF_BIT] = pwr;
        lane_word[LCRF_SPARE_MSB:LCRF_SPARE_LSB] = spr;
    endfunction

    assign hit = lane_hit(paddr);
    // word latched once per transfer, at the first enabled edge with psel high
    assign capture = psel && clk_en && !loaded_reg;
    // ready waits for the latch, so a setup cycle under a low enable still reads fresh data
    assign pready = clk_en && loaded_reg;
    assign access = psel && penable && pready;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            loaded_reg <= 1'b0;
        end else if (clk_en) begin
            if (!psel || access) begin
                loaded_reg <= 1'b0;
            end else if (capture) begin
                loaded_reg <= 1'b1;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_lane
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    invert_reg[g] <= LCRF_INVERT_RST; // see R5 see R6
                end else if (access && pwrite && hit[g]) begin
                    invert_reg[g] <= pwdata[LCRF_INVERT_BIT]; // see R5 see R6
                end
            end

            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    power_off_reg[g] <= LCRF_POWER_OFF_RST; // see R1 see R2
                end else if (access && pwrite && hit[g]) begin
                    // stored on every variant, even where the lane ignores it
                    power_off_reg[g] <= pwdata[LCRF_POWER_OFF_BIT]; // see R8
                end
            end

            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    spare_reg[g] <= LCRF_SPARE_RST; // see R7
                end else if (access && pwrite && hit[g]) begin
                    spare_reg[g] <= pwdata[LCRF_SPARE_MSB:LCRF_SPARE_LSB]; // see R7 see R9
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            prdata_reg <= '0;
        end else if (capture) begin
            prdata_reg <= '0; // see R9
            if (!pwrite && hit[0]) begin
                prdata_reg <= lane_word(invert_reg[0], power_off_reg[0], spare_reg[0]);
            end else if (!pwrite && hit[1]) begin
                prdata_reg <= lane_word(invert_reg[1], power_off_reg[1], spare_reg[1]);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pslverr_reg <= 1'b0;
        end else if (capture) begin
            // unmapped addresses answer with an error instead of silently dropping
            pslverr_reg <= (hit == 2'b00);
        end else if (access) begin
            pslverr_reg <= 1'b0;
        end
    end

    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg && access;

    // other lanes are not held here and stay in normal mode
    always_comb begin
        lane_power_off = '0;
        lane_power_off[LCRF_LANE_FOUR] = power_off_reg[0]; // see R2 see R3
        lane_power_off[LCRF_LANE_FIVE] = power_off_reg[1]; // see R1 see R3
    end
    assign lane_four_invert = invert_reg[0];
    assign lane_five_invert = invert_reg[1];
    assign lane_four_spare = spare_reg[0];
    assign lane_five_spare = spare_reg[1];

    pwr_five_write_a: assert property (@(posedge clk) disable iff (!rst_b) // see R1
        access && pwrite && hit[1]
        |=> lane_power_off[LCRF_LANE_FIVE] == $past(pwdata[LCRF_POWER_OFF_BIT]))
        else $error("lane five power-off not written");

    pwr_four_write_a: assert property (@(posedge clk) disable iff (!rst_b) // see R2
        access && pwrite && hit[0]
        |=> lane_power_off[LCRF_LANE_FOUR] == $past(pwdata[LCRF_POWER_OFF_BIT]))
        else $error("lane four power-off not written");

    pwr_vector_map_a: assert property (@(posedge clk) disable iff (!rst_b) // see R3
        lane_power_off[5:4] == power_off_reg && lane_power_off[3:0] == 4'h0
        && lane_power_off[7:6] == 2'h0)
        else $error("power-off vector mapping wrong");

    pwr_stable_a: assert property (@(posedge clk) disable iff (!rst_b) // see R1 see R2
        !(access && pwrite) |=> $stable(lane_power_off))
        else $error("power-off changed without write");

    inv_four_write_a: assert property (@(posedge clk) disable iff (!rst_b) // see R5
        access && pwrite && hit[0] |=> lane_four_invert == $past(pwdata[LCRF_INVERT_BIT]))
        else $error("lane four invert not written");

    inv_five_write_a: assert property (@(posedge clk) disable iff (!rst_b) // see R6
        access && pwrite && hit[1] |=> lane_five_invert == $past(pwdata[LCRF_INVERT_BIT]))
        else $error("lane five invert not written");

    inv_stable_a: assert property (@(posedge clk) disable iff (!rst_b) // see R5 see R6
        !(access && pwrite) |=> $stable(lane_four_invert) && $stable(lane_five_invert))
        else $error("invert changed without write");

    spare_write_a: assert property (@(posedge clk) disable iff (!rst_b) // see R7
        access && pwrite && hit[0]
        |=> lane_four_spare == $past(pwdata[LCRF_SPARE_MSB:LCRF_SPARE_LSB]))
        else $error("lane four spare not written");

    spare_five_write_a: assert property (@(posedge clk) disable iff (!rst_b) // see R7
        access && pwrite && hit[1]
        |=> lane_five_spare == $past(pwdata[LCRF_SPARE_MSB:LCRF_SPARE_LSB]))
        else $error("lane five spare not written");

    spare_stable_a: assert property (@(posedge clk) disable iff (!rst_b) // see R7
        !(access && pwrite) |=> $stable(lane_four_spare) && $stable(lane_five_spare))
        else $error("spare changed without write");

    pwr_readback_a: assert property (@(posedge clk) disable iff (!rst_b) // see R8
        capture && !pwrite && hit[1]
        |=> prdata[LCRF_POWER_OFF_BIT] == lane_power_off[LCRF_LANE_FIVE])
        else $error("power-off readback wrong");

    rd_four_word_a: assert property (@(posedge clk) disable iff (!rst_b) // see R5 see R7
        capture && !pwrite && hit[0]
        |=> prdata == lane_word(lane_four_invert, lane_power_off[LCRF_LANE_FOUR],
            lane_four_spare))
        else $error("lane four readback wrong");

    rd_five_word_a: assert property (@(posedge clk) disable iff (!rst_b) // see R6 see R7
        capture && !pwrite && hit[1]
        |=> prdata == lane_word(lane_five_invert, lane_power_off[LCRF_LANE_FIVE],
            lane_five_spare))
        else $error("lane five readback wrong");

    rsvd_zero_a: assert property (@(posedge clk) disable iff (!rst_b) // see R9
        prdata[31:10] == 22'h000000)
        else $error("reserved bits not zero");

    rst_pwr_a: assert property (@(posedge clk) // see R1 see R2
        !rst_b |=> lane_power_off == 8'h00)
        else $error("power-off not cleared by reset");

    rst_inv_a: assert property (@(posedge clk) // see R5 see R6
        !rst_b |=> lane_four_invert == LCRF_INVERT_RST && lane_five_invert == LCRF_INVERT_RST)
        else $error("invert not cleared by reset");

    rst_spare_a: assert property (@(posedge clk) // see R7
        !rst_b
        |=> lane_four_spare == LCRF_SPARE_RST && lane_five_spare == LCRF_SPARE_RST)
        else $error("spare not cleared by reset");

    enable_freeze_a: assert property (@(posedge clk) disable iff (!rst_b) // see R1 see R2 see R7
        !clk_en |=> $stable(lane_power_off) && $stable(lane_four_spare)
            && $stable(lane_five_spare) && $stable(prdata))
        else $error("state moved while enable low");
endmodule // lcrf_lane_regs
`default_nettype wire

// [verilog/lcrf_pkg.sv]
`default_nettype none
package lcrf_pkg;
    localparam int LCRF_ADDR_W = 8;
    localparam int LCRF_DATA_W = 32;
    // lane 4 offset sits one word below lane 5
    localparam logic [7:0] LCRF_LANE_FOUR_CONTROL_OFF = 8'h14;
    localparam logic [7:0] LCRF_LANE_FIVE_CONTROL_OFF = 8'h18;
    localparam int LCRF_INVERT_BIT = 0;
    localparam int LCRF_POWER_OFF_BIT = 1;
    localparam int LCRF_SPARE_LSB = 2;
    localparam int LCRF_SPARE_MSB = 9;
    localparam int LCRF_SPARE_W = 8;
    localparam logic LCRF_INVERT_RST = 1'h0;
    localparam logic LCRF_POWER_OFF_RST = 1'h0;
    localparam logic [7:0] LCRF_SPARE_RST = 8'h00;
    localparam int LCRF_LANES = 8;
    localparam int LCRF_LANE_FOUR = 4;
    localparam int LCRF_LANE_FIVE = 5;
endpackage
`default_nettype wire

// [testbench/lcrf_lane_regs_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module lcrf_lane_regs_tb;
    import lcrf_pkg::*;
    logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
    logic clk_en = 1'b1, stall = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, v4, v5;
    logic pready, pslverr, f4, f5;
    logic [7:0] lpo, s4, s5;
    logic [32:0] expq[$];
    int err_total = 0, comparisons = 0, cyc = 0;
    integer seed = 32'h6c66;
    always #20 clk = ~clk;
    lcrf_lane_regs DUT (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .lane_power_off(lpo),
        .lane_four_invert(f4), .lane_five_invert(f5), .lane_four_spare(s4),
        .lane_five_spare(s5));
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // one idle edge after release, so back-to-back calls never re-drive psel in one step
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] exp);
        expq.push_back(exp);
        apb(a, 1'b0, 32'h0);
    endtask
    // read results are judged where they appear, against the oldest note
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (psel && penable && pready && !pwrite && expq.size() > 0)
            chk({pslverr, prdata}, expq.pop_front());
        if (cyc > 3000) begin
            err_total++;
            close_out();
        end
    end
    // random enable stalls stretch transfers; every register must hold meanwhile
    always @(posedge clk) begin
        if (stall) clk_en <= ($random(seed) & 32'h3) != 32'h0;
        else clk_en <= 1'b1;
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        chk({lpo, f4, f5, s4, s5}, 33'h0);
        rd(LCRF_LANE_FOUR_CONTROL_OFF, 33'h0);
        rd(LCRF_LANE_FIVE_CONTROL_OFF, 33'h0);
        $display("reset test done");
        stall <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            v4 = $random(seed);
            v5 = $random(seed);
            apb(LCRF_LANE_FOUR_CONTROL_OFF, 1'b1, v4);
            apb(LCRF_LANE_FIVE_CONTROL_OFF, 1'b1, v5);
            chk(lpo, {2'b00, v5[1], v4[1], 4'h0});
            chk({f5, f4, s5, s4}, {v5[0], v4[0], v5[9:2], v4[9:2]});
            rd(LCRF_LANE_FOUR_CONTROL_OFF, {1'b0, v4 & 32'h3FF});
            rd(LCRF_LANE_FIVE_CONTROL_OFF, {1'b0, v5 & 32'h3FF});
        end
        apb(8'h1C, 1'b1, 32'hFFFF_FFFF);
        chk({f5, f4, s5, s4}, {v5[0], v4[0], v5[9:2], v4[9:2]});
        rd(8'h1C, {1'b1, 32'h0});
        $display("write and unmapped test done");
        stall <= 1'b0;
        apb(LCRF_LANE_FOUR_CONTROL_OFF, 1'b1, 32'hFFFF_FFFF);
        apb(LCRF_LANE_FIVE_CONTROL_OFF, 1'b1, 32'hFFFF_FFFF);
        chk(lpo, 8'h30);
        chk({f5, f4, s5, s4}, {2'b11, 16'hFFFF});
        rd(LCRF_LANE_FOUR_CONTROL_OFF, {1'b0, 32'h0000_03FF});
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        chk({lpo, f4, f5, s4, s5}, 33'h0);
        rd(LCRF_LANE_FIVE_CONTROL_OFF, 33'h0);
        $display("mid-run reset test done");
        close_out();
    end
endmodule // lcrf_lane_regs_tb
`default_nettype wire
